/* core/cc_channel_pkg.sv */
// Package for one capture/compare channel: register layouts and mode codes.
// Assumes a host-side register access port and a shared 16-bit counter.
package cc_channel_pkg;

  // ****************************************
  // Register selectors on the access port
  // ****************************************
  localparam logic [2:0] SEL_MODE = 3'h0;
  localparam logic [2:0] SEL_PWMCFG = 3'h1;
  localparam logic [2:0] SEL_CMP_LO = 3'h2;
  localparam logic [2:0] SEL_CMP_HI = 3'h3;
  localparam logic [2:0] SEL_FLAG = 3'h4;

  // ****************************************
  // Mode register fields
  // ****************************************
  localparam int MODE_WIDE = 7;
  localparam int MODE_CMP_EN = 6;
  localparam int MODE_RISE = 5;
  localparam int MODE_FALL = 4;
  localparam int MODE_MATCH = 3;
  localparam int MODE_TOGGLE = 2;
  localparam int MODE_MOD = 1;
  localparam int MODE_IRQ = 0;

  // ****************************************
  // Shared PWM configuration fields
  // ****************************************
  localparam int PCFG_RELOAD_SEL = 7;
  localparam int PCFG_OVF_IRQ = 5;
  localparam int PCFG_LEN_HI = 1;
  localparam int PCFG_LEN_LO = 0;
  localparam logic [7:0] PCFG_RW_MASK = 8'ha3;

  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PCFG_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [1:0] LEN_8BIT = 2'h0;
  localparam logic [8:0] FREQ_ZERO_HALF = 9'h100;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_CAPTURE = 3'b001,
    M_TIMER = 3'b010,
    M_HSO = 3'b011,
    M_FREQ = 3'b100,
    M_PWM_N = 3'b101,
    M_PWM16 = 3'b110
  } mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] value;
    logic [15:0] prev;
  } counter_t;

endpackage : cc_channel_pkg

/* core/capture_compare_channel.sv */
// One capture/compare channel of a counter array with its shared PWM config.
// Assumes the counter is supplied each clock with its previous value and the
// register port is a simple one-cycle strobe interface from the processor.
`timescale 1ns/1ns
module capture_compare_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire cc_channel_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // Shared counter
  input wire cc_channel_pkg::counter_t cnt,
  // Channel pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pin_level,
  // Events
  output logic event_flag,
  output logic overflow_flag,
  output logic irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] low_mask(input logic [1:0] cl);
    low_mask = 16'h00ff;
    case (cl)
      2'h1: low_mask = 16'h01ff;
      2'h2: low_mask = 16'h03ff;
      2'h3: low_mask = 16'h07ff;
      default: low_mask = 16'h00ff;
    endcase
  endfunction : low_mask

  function automatic logic is_match(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
    is_match = ((a ^ b) & m) == 16'h0000;
  endfunction : is_match

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] mode_q;
  logic [7:0] pcfg_q;
  logic [15:0] cmp_q;
  logic [15:0] reload_q;
  logic flag_q;
  logic ovf_q;
  logic out_q;
  logic sync1_q, sync2_q, sync3_q;
  logic [7:0] rdata_q;
  logic irq_q;

  cc_channel_pkg::mode_t mode;
  logic [15:0] nmask;
  logic narrow_ovf, wide_ovf, low_ovf;
  logic rise, fall, capture;
  logic cmp_en;
  logic pwm_match, full_match, freq_match;
  logic wr_lo, wr_hi;
  logic [8:0] half;

  assign cmp_en = mode_q[cc_channel_pkg::MODE_CMP_EN];
  // One length for every narrow PWM channel, held in the shared config
  assign nmask = low_mask(pcfg_q[cc_channel_pkg::PCFG_LEN_HI:cc_channel_pkg::PCFG_LEN_LO]);
  // Overflow seen as counter bits below N wrapping to zero
  assign narrow_ovf = ((cnt.value & nmask) == 16'h0000) && ((cnt.prev & nmask) == nmask);
  assign low_ovf = (cnt.value[7:0] == 8'h00) && (cnt.prev[7:0] == 8'hff);
  assign wide_ovf = (cnt.value == 16'h0000) && (cnt.prev == 16'hffff);
  assign full_match = is_match(cnt.value, cmp_q, 16'hffff) && (cnt.value != cnt.prev);
  assign pwm_match = is_match(cnt.value, cmp_q, nmask) && (cnt.value != cnt.prev);
  assign freq_match = (cnt.value[7:0] == cmp_q[7:0]) && (cnt.value != cnt.prev);
  // 0x00 counts as 256 counter clocks
  assign half = (cmp_q[15:8] == 8'h00) ? cc_channel_pkg::FREQ_ZERO_HALF : {1'b0, cmp_q[15:8]};

  // ****************************************
  // Mode decode
  // ****************************************
  always_comb begin
    mode = cc_channel_pkg::M_IDLE;
    if (mode_q[cc_channel_pkg::MODE_MOD]) begin
      if (mode_q[cc_channel_pkg::MODE_TOGGLE]) begin
        mode = cc_channel_pkg::M_FREQ;
      end else if (mode_q[cc_channel_pkg::MODE_WIDE]) begin
        mode = cc_channel_pkg::M_PWM16;
      end else begin
        mode = cc_channel_pkg::M_PWM_N;
      end
    end else if (mode_q[cc_channel_pkg::MODE_RISE] || mode_q[cc_channel_pkg::MODE_FALL]) begin
      mode = cc_channel_pkg::M_CAPTURE;
    end else if (mode_q[cc_channel_pkg::MODE_TOGGLE]) begin
      mode = cc_channel_pkg::M_HSO;
    end else if (mode_q[cc_channel_pkg::MODE_MATCH]) begin
      mode = cc_channel_pkg::M_TIMER;
    end
  end

  // ****************************************
  // Pin synchroniser and edge detect
  // ****************************************
  // Levels shorter than one clock may be missed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign rise = sync2_q && !sync3_q;
  assign fall = !sync2_q && sync3_q;
  // At most one capture per clock, even with both edges enabled
  assign capture = (mode == cc_channel_pkg::M_CAPTURE) &&
                   ((rise && mode_q[cc_channel_pkg::MODE_RISE]) || (fall && mode_q[cc_channel_pkg::MODE_FALL]));

  assign wr_lo = req.wr && (req.sel == cc_channel_pkg::SEL_CMP_LO);
  assign wr_hi = req.wr && (req.sel == cc_channel_pkg::SEL_CMP_HI);

  // ****************************************
  // Mode and shared PWM config registers
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= cc_channel_pkg::MODE_RESET;
    end else if (req.wr && req.sel == cc_channel_pkg::SEL_MODE) begin
      mode_q <= req.wdata;
    end else if (wr_lo && !pcfg_q[cc_channel_pkg::PCFG_RELOAD_SEL]) begin
      mode_q[cc_channel_pkg::MODE_CMP_EN] <= 1'b0;
    end else if (wr_hi && !pcfg_q[cc_channel_pkg::PCFG_RELOAD_SEL]) begin
      mode_q[cc_channel_pkg::MODE_CMP_EN] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pcfg_q <= cc_channel_pkg::PCFG_RESET;
    end else if (req.wr && req.sel == cc_channel_pkg::SEL_PWMCFG) begin
      pcfg_q <= req.wdata & cc_channel_pkg::PCFG_RW_MASK;
    end
  end

  // ****************************************
  // Compare and reload registers
  // ****************************************
  // Reload select steers byte writes to the reload copy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reload_q <= cc_channel_pkg::CMP_RESET;
    end else if (pcfg_q[cc_channel_pkg::PCFG_RELOAD_SEL]) begin
      if (wr_lo) begin
        reload_q[7:0] <= req.wdata;
      end else if (wr_hi) begin
        reload_q[15:8] <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmp_q <= cc_channel_pkg::CMP_RESET;
    end else if (wr_lo && !pcfg_q[cc_channel_pkg::PCFG_RELOAD_SEL]) begin
      cmp_q[7:0] <= req.wdata;
    end else if (wr_hi && !pcfg_q[cc_channel_pkg::PCFG_RELOAD_SEL]) begin
      cmp_q[15:8] <= req.wdata;
    end else if (capture) begin
      cmp_q <= cnt.value;
    end else if (mode == cc_channel_pkg::M_FREQ && cmp_en && freq_match) begin
      cmp_q[7:0] <= 8'((cmp_q[7:0] + half[7:0]));
    end else if (mode == cc_channel_pkg::M_PWM_N && low_ovf &&
                 pcfg_q[cc_channel_pkg::PCFG_LEN_HI:cc_channel_pkg::PCFG_LEN_LO] == cc_channel_pkg::LEN_8BIT) begin
      cmp_q[7:0] <= cmp_q[15:8];
    end else if (mode == cc_channel_pkg::M_PWM_N && narrow_ovf) begin
      cmp_q <= reload_q & nmask;
    end
  end

  // ****************************************
  // Channel output
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= 1'b0;
    end else begin
      case (mode)
        cc_channel_pkg::M_HSO: begin
          if (cmp_en && full_match) begin
            out_q <= !out_q;
          end
        end
        cc_channel_pkg::M_FREQ: begin
          if (cmp_en && freq_match) begin
            out_q <= !out_q;
          end
        end
        cc_channel_pkg::M_PWM_N: begin
          if (!cmp_en) begin
            out_q <= 1'b0;
          end else if (pwm_match) begin
            out_q <= 1'b1; // Match first: zero compare gives full duty
          end else if (narrow_ovf) begin
            out_q <= 1'b0;
          end
        end
        cc_channel_pkg::M_PWM16: begin
          if (!cmp_en) begin
            out_q <= 1'b0;
          end else if (full_match) begin
            out_q <= 1'b1; // Match first: zero compare gives full duty
          end else if (wide_ovf) begin
            out_q <= 1'b0;
          end
        end
        default: begin
          out_q <= out_q;
        end
      endcase
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  logic set_flag, clr_flag, set_ovf, clr_ovf;
  always_comb begin
    set_flag = capture;
    case (mode)
      cc_channel_pkg::M_TIMER, cc_channel_pkg::M_HSO, cc_channel_pkg::M_FREQ: begin
        set_flag = cmp_en && mode_q[cc_channel_pkg::MODE_MATCH] && full_match;
      end
      cc_channel_pkg::M_PWM_N: begin
        set_flag = cmp_en && mode_q[cc_channel_pkg::MODE_MATCH] && pwm_match;
      end
      cc_channel_pkg::M_PWM16: begin
        set_flag = cmp_en && mode_q[cc_channel_pkg::MODE_MATCH] && full_match;
      end
      default: begin
        set_flag = capture;
      end
    endcase
  end

  assign clr_flag = req.wr && req.sel == cc_channel_pkg::SEL_FLAG && !req.wdata[0];
  assign clr_ovf = req.wr && req.sel == cc_channel_pkg::SEL_PWMCFG && !req.wdata[6];
  assign set_ovf = narrow_ovf;

  // Set beats a clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      flag_q <= set_flag || (flag_q && !clr_flag);
      ovf_q <= set_ovf || (ovf_q && !clr_ovf);
    end
  end

  // ****************************************
  // Read data, interrupt and pin outputs
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      case (req.sel)
        cc_channel_pkg::SEL_MODE: rdata_q <= mode_q;
        cc_channel_pkg::SEL_PWMCFG: rdata_q <= pcfg_q | {1'b0, ovf_q, 6'h00};
        cc_channel_pkg::SEL_CMP_LO: rdata_q <= pcfg_q[cc_channel_pkg::PCFG_RELOAD_SEL] ? reload_q[7:0] : cmp_q[7:0];
        cc_channel_pkg::SEL_CMP_HI: rdata_q <= pcfg_q[cc_channel_pkg::PCFG_RELOAD_SEL] ? reload_q[15:8] : cmp_q[15:8];
        cc_channel_pkg::SEL_FLAG: rdata_q <= {7'h00, flag_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (flag_q && mode_q[cc_channel_pkg::MODE_IRQ]) ||
               (ovf_q && pcfg_q[cc_channel_pkg::PCFG_OVF_IRQ]);
    end
  end

  logic oe_n_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= (mode == cc_channel_pkg::M_CAPTURE) || (mode == cc_channel_pkg::M_IDLE) ||
                (mode == cc_channel_pkg::M_TIMER);
    end
  end

  assign rdata = rdata_q;
  assign pin_out = out_q;
  assign pin_oe_n = oe_n_q;
  assign pin_level = sync2_q;
  assign event_flag = flag_q;
  assign overflow_flag = ovf_q;
  assign irq = irq_q;

endmodule : capture_compare_channel

/* verif/pin_source.sv */
// Partner model: the signal source that stands on the channel pin.
// Assumes the bench changes the wanted level on rising clock edges.
`timescale 1ns/1ns
module pin_source (
  // Clock
  input wire logic clk,
  // Wanted level and channel drive
  input wire logic want,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // Resolved pin
  output logic pin_wire
);
  logic src_q = 1'b0;
  logic [1:0] age_q = 2'h0;
  // A new level waits until the old one has stood two clocks
  always @(posedge clk) begin
    if (want != src_q && age_q != 2'h0) begin
      src_q <= want;
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  assign pin_wire = pin_oe_n ? src_q : pin_out;
endmodule : pin_source

/* verif/capture_compare_channel_checker.sv */
// Port checker for one capture/compare channel, bound into the design.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ns
module capture_compare_channel_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire cc_channel_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  // Counter and pin
  input wire cc_channel_pkg::counter_t cnt,
  input wire logic pin_in,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic pin_level,
  // Events
  input wire logic event_flag,
  input wire logic overflow_flag,
  input wire logic irq
);
  logic lvl_q;
  logic step;
  logic lvl_edge;
  assign step = cnt.value != cnt.prev;
  assign lvl_edge = pin_level != lvl_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= pin_level;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // Assertions
  // ****************************************
  AST_IRQ_CAUSE: assert property (irq |-> $past(event_flag) || $past(overflow_flag))
    else $error("irq without a flag");
  AST_FLAG_CLEAR: assert property ($fell(event_flag) |->
    $past(req.wr) && $past(req.sel) == cc_channel_pkg::SEL_FLAG && !$past(req.wdata[0]))
    else $error("event flag cleared without a write");
  AST_OVF_CLEAR: assert property ($fell(overflow_flag) |->
    $past(req.wr) && $past(req.sel) == cc_channel_pkg::SEL_PWMCFG && !$past(req.wdata[6]))
    else $error("overflow flag cleared without a write");
  AST_CFG_READ: assert property ($past(req.rd) && $past(req.sel) == cc_channel_pkg::SEL_PWMCFG |->
    rdata[4:2] == 3'h0 && rdata[6] == $past(overflow_flag))
    else $error("config read shows wrong bits");
  AST_LEVEL_SYNC: assert property ($past(nrst) && $past(nrst, 2) |-> pin_level == $past(pin_in, 2))
    else $error("pin level not two clocks behind pin");
  AST_RDATA_HOLD: assert property (!$past(req.rd) |-> $stable(rdata))
    else $error("read data moved without a read");
  AST_FLAG_CAUSE: assert property ($rose(event_flag) |-> $past(step) || $past(lvl_edge) || $past(lvl_edge, 2))
    else $error("event flag set without match or edge");
  AST_PIN_CAUSE: assert property ($changed(pin_out) |-> $past(step) || $past(req.wr) || $past(req.wr, 2))
    else $error("pin moved without counter step or write");
  AST_OE_RESET: assert property (!$past(nrst) |-> pin_oe_n)
    else $error("pin driven right after reset");
  COV_CAPTURE: cover property ($rose(event_flag) && $past(lvl_edge));
  COV_IRQ: cover property ($rose(irq));
  COV_TOGGLE: cover property ($changed(pin_out) && !pin_oe_n);
endmodule : capture_compare_channel_checker
bind capture_compare_channel capture_compare_channel_checker capture_compare_channel_checker_i (.clk(clk),
  .nrst(nrst), .req(req), .rdata(rdata), .cnt(cnt), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pin_level(pin_level), .event_flag(event_flag), .overflow_flag(overflow_flag), .irq(irq));

/* verif/capture_compare_channel_tb.sv */
// Testbench for the capture/compare channel: register tasks, counter stub, scenarios.
// Assumes the pin source partner and the bound checker are compiled with it.
`timescale 1ns/1ns
module capture_compare_channel_tb;
  localparam logic [2:0] S_MODE = cc_channel_pkg::SEL_MODE;
  localparam logic [2:0] S_CFG = cc_channel_pkg::SEL_PWMCFG;
  localparam logic [2:0] S_LO = cc_channel_pkg::SEL_CMP_LO;
  localparam logic [2:0] S_HI = cc_channel_pkg::SEL_CMP_HI;
  localparam logic [2:0] S_FLAG = cc_channel_pkg::SEL_FLAG;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cc_channel_pkg::reg_req_t req = '0;
  cc_channel_pkg::counter_t cnt = '0;
  logic [7:0] rdata;
  logic pin_wire, pin_out, pin_oe_n, pin_level, event_flag, overflow_flag, irq;
  logic want = 1'b0;
  logic ld = 1'b0;
  logic [15:0] ldv = '0;
  logic [15:0] lim = '0;
  int mismatches = 0;
  int checks_done = 0;
  always #25 clk = ~clk;
  capture_compare_channel capture_compare_channel_i (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
    .cnt(cnt), .pin_in(pin_wire), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level),
    .event_flag(event_flag), .overflow_flag(overflow_flag), .irq(irq));
  pin_source pin_source_i (.clk(clk), .want(want), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_wire(pin_wire));
  // ****************************************
  // Shared counter stub
  // ****************************************
  // Steps once a clock until lim; a load never counts as a step
  always @(posedge clk) begin
    if (ld) begin
      cnt <= '{value: ldv, prev: ldv};
    end else if (cnt.value != lim) begin
      cnt <= '{value: cnt.value + 16'h1, prev: cnt.value};
    end else begin
      cnt.prev <= cnt.value;
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic bchk(input string n, input logic seen, input logic exp);
    chk(n, 16'(seen), 16'(exp));
  endtask : bchk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task automatic rchk(input string n, input logic [2:0] s, input logic [7:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk(n, 16'(rdata), 16'(e));
  endtask : rchk
  task automatic go(input logic [15:0] v, input logic [15:0] l);
    @(posedge clk);
    ld <= 1'b1;
    ldv <= v;
    lim <= l;
    @(posedge clk);
    ld <= 1'b0;
    #1;
  endtask : go
  task automatic run(input logic [15:0] v, input logic [15:0] l);
    go(v, l);
    for (int i = 0; i < 70000 && cnt.value !== l; i++) @(posedge clk);
    wt(4);
  endtask : run
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_capture();
    logic [7:0] cm [6] = '{8'h21, 8'h21, 8'h11, 8'h11, 8'h31, 8'h31};
    logic st [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic ex [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    bchk("oe_n", pin_oe_n, 1'b1);
    for (int s = 0; s < 5; s++) rchk("reset reg", 3'(s), 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(S_MODE, 8'h00);
      want <= st[i];
      run(16'h1200 + 16'(i), 16'h1200 + 16'(i));
      wr(S_MODE, cm[i]);
      wr(S_FLAG, 8'h00);
      want <= ~st[i];
      wt(8);
      bchk("capture flag", event_flag, ex[i]);
      bchk("capture irq", irq, ex[i]);
      bchk("pin level", pin_level, ~st[i]);
      if (ex[i]) begin
        rchk("capture lo", S_LO, 8'(i));
        rchk("capture hi", S_HI, 8'h12);
      end
    end
    wr(S_FLAG, 8'h00);
    $display("capture test done");
  endtask : t_capture
  task automatic t_timer_hso();
    logic p;
    wr(S_MODE, 8'h09);
    wr(S_LO, 8'h10);
    rchk("mode after lo", S_MODE, 8'h09);
    wr(S_HI, 8'h01);
    rchk("mode after hi", S_MODE, 8'h49);
    run(16'h0000, 16'h0010);
    bchk("timer early", event_flag, 1'b0);
    run(16'h0011, 16'h0110);
    bchk("timer flag", event_flag, 1'b1);
    bchk("timer irq", irq, 1'b1);
    wr(S_FLAG, 8'h00);
    wr(S_MODE, 8'h0c);
    wr(S_LO, 8'h20);
    wr(S_HI, 8'h00);
    wt(2);
    p = pin_out;
    bchk("hso drive", pin_oe_n, 1'b0);
    run(16'h0000, 16'h0020);
    bchk("hso toggle", pin_out, ~p);
    bchk("hso flag", event_flag, 1'b1);
    wr(S_LO, 8'h20);
    run(16'h0000, 16'h0020);
    bchk("hso hold", pin_out, ~p);
    wr(S_FLAG, 8'h00);
    $display("timer and hso test done");
  endtask : t_timer_hso
  task automatic t_freq(input logic [7:0] hi, input int gap);
    int n;
    logic p;
    wr(S_MODE, 8'h06);
    wr(S_LO, 8'h00);
    wr(S_HI, hi);
    go(16'h0000, 16'hffff);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      p = pin_out;
      while (pin_out === p && n < 600) begin
        wt(1);
        n++;
      end
    end
    chk("freq half period", 16'(n), 16'(gap));
    go(16'h0000, 16'h0000);
    $display("freq test done");
  endtask : t_freq
  task automatic t_pwm();
    wr(S_CFG, 8'h20);
    wr(S_MODE, 8'h0a);
    wr(S_LO, 8'h40);
    wr(S_HI, 8'h40);
    run(16'h0000, 16'h0060);
    bchk("pwm8 high", pin_out, 1'b1);
    bchk("pwm8 flag", event_flag, 1'b1);
    bchk("pwm8 no irq", irq, 1'b0);
    run(16'h0061, 16'h0101);
    bchk("pwm8 low", pin_out, 1'b0);
    bchk("pwm8 ovf irq", irq, 1'b1);
    rchk("cfg read", S_CFG, 8'h60);
    wr(S_CFG, 8'h00);
    wr(S_FLAG, 8'h00);
    wt(2);
    bchk("ovf cleared", overflow_flag, 1'b0);
    wr(S_LO, 8'h40);
    run(16'h0102, 16'h0160);
    bchk("pwm8 off", pin_out, 1'b0);
    wr(S_CFG, 8'h81);
    wr(S_LO, 8'h80);
    wr(S_HI, 8'h01);
    rchk("reload no enable", S_MODE, 8'h0a);
    rchk("reload lo", S_LO, 8'h80);
    wr(S_CFG, 8'h01);
    rchk("compare lo", S_LO, 8'h40);
    wr(S_MODE, 8'h4a);
    run(16'h0000, 16'h0370);
    bchk("pwm9 ovf", overflow_flag, 1'b1);
    bchk("pwm9 before", pin_out, 1'b0);
    run(16'h0371, 16'h0390);
    bchk("pwm9 match", pin_out, 1'b1);
    rchk("reloaded hi", S_HI, 8'h01);
    wr(S_MODE, 8'h8a);
    wr(S_LO, 8'h00);
    wr(S_HI, 8'h03);
    run(16'hfffe, 16'h0002);
    bchk("pwm16 wrap", pin_out, 1'b0);
    run(16'h0003, 16'h02f0);
    bchk("pwm16 before", pin_out, 1'b0);
    run(16'h02f1, 16'h0380);
    bchk("pwm16 match", pin_out, 1'b1);
    $display("pwm test done");
  endtask : t_pwm
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    wt(1);
    t_capture();
    t_timer_hso();
    t_freq(8'h04, 4);
    t_freq(8'h00, 256);
    t_pwm();
    finish_test();
  end
  // Whole run needs well under 10000 clocks
  initial begin
    #(50 * 30000);
    mismatches++;
    finish_test();
  end
endmodule : capture_compare_channel_tb
